// File: pulse_train_map.svh
// Register offsets, field codes, reset values and timing figures of the pulse output unit
`ifndef PULSE_TRAIN_MAP_SVH
`define PULSE_TRAIN_MAP_SVH

`define CLK_HZ        32'h05f5e100
`define FREQ_UNIT_HZ  32'h0000000a
`define NCO_HALF      (`CLK_HZ / (32'h2 * `FREQ_UNIT_HZ))
`define FREQ_MAX      16'h1388
`define RAMP_STEP_MS  32'h00000004
`define PWM_F0_KHZ    5.9
`define PWM_F1_KHZ    1.5
`define PWM_F2_HZ     91.6

`define OFF_PORT      16'h0001
`define OFF_MODE      16'h0002
`define OFF_OPA       16'h0003
`define OFF_OPB       16'h0004
`define OFF_OPC       16'h0005
`define OFF_OPD       16'h0006
`define OFF_CNT_LO    16'h0007
`define OFF_CNT_HI    16'h0008
`define OFF_DEC_LO    16'h0009
`define OFF_DEC_HI    16'h000a
`define OFF_CMD       16'h000b
`define OFF_RESULT    16'h000c
`define OFF_STAT1     16'h000d
`define OFF_STAT2     16'h000e
`define OFF_RDSTAT    16'h000f
`define OFF_RUN       16'h0010
`define OFF_PMODE     16'h19d3
`define OFF_TYPE1     16'h19f3
`define OFF_TYPE2     16'h19f4

`define PMODE_RST     16'h0000
`define TYPE_RST      16'h0000
`define MODE_COUNTER  16'h0000
`define MODE_PULSE    16'h0001
`define TYPE_STD      16'h0000
`define TYPE_DUTY     16'h1000
`define PORT1         16'h0001
`define PORT2         16'h0002
`define STOP_CODE     16'h0003
`define SPEED_INDEP   16'h0000
`define SPEED_CONT    16'h0001
`define PWM_CODE_MAX  16'h0002
`define RES_OK        2'h1
`define RES_REFUSED   2'h2

`endif

// File: pulse_train_pkg.sv
// Types shared by the pulse output unit
package pulse_train_pkg;

	typedef enum logic [3:0] {
		OP_SPEED  = 4'h1,
		OP_COUNT  = 4'h2,
		OP_TRAP   = 4'h3,
		OP_ACCEL  = 4'h4,
		OP_DUTY   = 4'h5,
		OP_STOP   = 4'h6,
		OP_TABLE  = 4'h7,
		OP_STATUS = 4'h8
	} cmd_op_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RUN  = 5'h02,
		ST_UP   = 5'h04,
		ST_DN   = 5'h08,
		ST_PWM  = 5'h10
	} port_state_type;

endpackage

// File: port_drive_if.sv
// Link from the port controller to one waveform generator
`timescale 1ns/1ps
interface port_drive_if;
	logic        std_en;
	logic [12:0] freq;
	logic        duty_en;
	logic [20:0] per;
	logic [20:0] high;
	logic        pulse_ev;
	logic        wave;

	modport ctl (output std_en, freq, duty_en, per, high, input pulse_ev, wave);
	modport gen (input std_en, freq, duty_en, per, high, output pulse_ev, wave);
endinterface

// File: pulse_gen.sv
// Waveform generator for one port: frequency synthesiser or fixed-period duty output
`timescale 1ns/1ps
`include "pulse_train_map.svh"
module pulse_gen (
	input  wire logic  clk,
	input  wire logic  rst_b,
	port_drive_if.gen  drv
);
	logic [22:0] acc_q;
	logic [20:0] cnt_q;
	logic        wave_q;
	logic        ev_q;
	logic [22:0] sum;

	assign sum = acc_q + 23'(drv.freq);
	assign drv.wave = wave_q;
	assign drv.pulse_ev = ev_q;

	////////////////////////////////////////////////////////////////////////////////
	// Accumulator wraps at half a period per 10 Hz unit, so each wrap is one edge
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			acc_q <= 23'h0;
			cnt_q <= 21'h0;
			wave_q <= 1'b0;
			ev_q <= 1'b0;
		end else if (drv.std_en) begin
			cnt_q <= 21'h0;
			if (sum >= 23'(`NCO_HALF)) begin
				acc_q <= sum - 23'(`NCO_HALF);
				wave_q <= !wave_q;
				ev_q <= !wave_q;
			end else begin
				acc_q <= sum;
				ev_q <= 1'b0;
			end
		end else if (drv.duty_en) begin
			acc_q <= 23'h0;
			ev_q <= 1'b0;
			cnt_q <= (cnt_q >= drv.per - 21'h1) ? 21'h0 : cnt_q + 21'h1;
			wave_q <= cnt_q < drv.high;
		end else begin
			acc_q <= 23'h0;
			cnt_q <= 21'h0;
			wave_q <= 1'b0;
			ev_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_gen_quiet: assert property (!drv.std_en && !drv.duty_en |=> !wave_q && !ev_q)
		else $error("waveform active with both outputs disabled");
	a_count_edge: assert property (ev_q |-> wave_q && !$past(wave_q))
		else $error("pulse event not on a rising edge");
endmodule

// File: pulse_train_top.sv
// Two-port pulse output unit: registers, command checking, ramps and pulse counting
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "pulse_train_map.svh"
module pulse_train_top #(
	parameter int unsigned RAMP_TICKS = `RAMP_STEP_MS * (`CLK_HZ / 32'h3e8),
	parameter int unsigned PWM_PER0   = $rtoi(`CLK_HZ / (`PWM_F0_KHZ * 1000.0)),
	parameter int unsigned PWM_PER1   = $rtoi(`CLK_HZ / (`PWM_F1_KHZ * 1000.0)),
	parameter int unsigned PWM_PER2   = $rtoi(`CLK_HZ / `PWM_F2_HZ)
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic      [1:0]  pulse_out,
	output logic      [1:0]  dir_out
);
	logic [15:0]                     pmode_q;
	logic [15:0]                     type_q [2];
	logic [15:0]                     op_port_q, op_mode_q, op_a_q, op_b_q, op_c_q, op_d_q;
	logic [15:0]                     cnt_lo_q, cnt_hi_q, dec_lo_q, dec_hi_q;
	logic [15:0]                     rdata_q;
	logic [15:0]                     rdstat_q;
	logic [1:0]                      result_q;
	logic                            run_q;
	logic                            started_q;
	logic                            active_pulse_q;
	logic [18:0]                     tick_q;
	logic                            tick;
	pulse_train_pkg::port_state_type st_q [2];
	logic [12:0]                     freq_q [2], tgt_q [2], rate_q [2], tgt2_q [2], rate2_q [2];
	logic [23:0]                     total_q [2], decpt_q [2], pv_q [2], acc_q [2];
	logic [20:0]                     per_q [2], high_q [2];
	logic [1:0]                      counted_q, trap_q, two_q, phase2_q, decel_q;
	logic [1:0]                      cnt_set_q, done_q, dir_q;
	logic [1:0]                      run_w, fin_w, std_en_w, duty_en_w, pulse_ev;
	logic [4:0]                      stat_w [2];
	pulse_train_pkg::cmd_op_type     op;
	logic                            cmd_go, go_ok, go, sel, port_ok;
	logic [23:0]                     count_w, decel_w;
	logic [20:0]                     per_sel, high_w;
	logic [6:0]                      duty_bin;
	logic                            duty_ok;

	function automatic logic freq_ok(input logic [15:0] v);
		return v != 16'h0 && v <= `FREQ_MAX;
	endfunction

	function automatic logic [6:0] bcd2(input logic [15:0] v);
		return 7'(v[7:4]) * 7'h0a + 7'(v[3:0]);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register writes; setup words only while the unit is stopped
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pmode_q <= `PMODE_RST;
			type_q[0] <= `TYPE_RST;
			type_q[1] <= `TYPE_RST;
			run_q <= 1'b0;
		end else if (wr && !run_q) begin
			if (addr == `OFF_PMODE) pmode_q <= wdata;
			if (addr == `OFF_TYPE1) type_q[0] <= wdata;
			if (addr == `OFF_TYPE2) type_q[1] <= wdata;
			if (addr == `OFF_RUN) run_q <= wdata[0];
		end else if (wr && addr == `OFF_RUN) begin
			run_q <= wdata[0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			op_port_q <= 16'h0;
			op_mode_q <= 16'h0;
			op_a_q <= 16'h0;
			op_b_q <= 16'h0;
			op_c_q <= 16'h0;
			op_d_q <= 16'h0;
			cnt_lo_q <= 16'h0;
			cnt_hi_q <= 16'h0;
			dec_lo_q <= 16'h0;
			dec_hi_q <= 16'h0;
		end else if (wr) begin
			if (addr == `OFF_PORT) op_port_q <= wdata;
			if (addr == `OFF_MODE) op_mode_q <= wdata;
			if (addr == `OFF_OPA) op_a_q <= wdata;
			if (addr == `OFF_OPB) op_b_q <= wdata;
			if (addr == `OFF_OPC) op_c_q <= wdata;
			if (addr == `OFF_OPD) op_d_q <= wdata;
			if (addr == `OFF_CNT_LO) cnt_lo_q <= wdata;
			if (addr == `OFF_CNT_HI) cnt_hi_q <= wdata;
			if (addr == `OFF_DEC_LO) dec_lo_q <= wdata;
			if (addr == `OFF_DEC_HI) dec_hi_q <= wdata;
		end
	end

	// Port mode is taken from the mode word and frozen the first time the unit leaves the stopped state
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			started_q <= 1'b0;
			active_pulse_q <= 1'b0;
		end else if (run_q && !started_q) begin
			started_q <= 1'b1;
			active_pulse_q <= pmode_q == `MODE_PULSE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tick_q <= 19'h0;
		end else begin
			tick_q <= (tick_q == 19'(RAMP_TICKS - 1)) ? 19'h0 : tick_q + 19'h1;
		end
	end
	assign tick = tick_q == 19'(RAMP_TICKS - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Command checking
	assign cmd_go = wr && addr == `OFF_CMD;
	assign op = pulse_train_pkg::cmd_op_type'(wdata[3:0]);
	assign sel = op_port_q == `PORT2;
	assign port_ok = op_port_q == `PORT1 || op_port_q == `PORT2;
	assign count_w = {cnt_hi_q[7:0], cnt_lo_q};
	assign decel_w = {dec_hi_q[7:0], dec_lo_q};
	assign duty_bin = bcd2(op_a_q);
	assign duty_ok = op_a_q[15:8] == 8'h0 && op_a_q[7:4] <= 4'h9 && op_a_q[3:0] <= 4'h9
		&& duty_bin != 7'h0;
	assign per_sel = (op_mode_q == 16'h0) ? 21'(PWM_PER0) :
		(op_mode_q == 16'h1) ? 21'(PWM_PER1) : 21'(PWM_PER2);
	assign high_w = 21'((28'(per_sel) * 28'(duty_bin)) / 28'h64);
	assign go = cmd_go && go_ok;

	always_comb begin
		go_ok = 1'b0;
		unique case (op)
			pulse_train_pkg::OP_SPEED: go_ok = port_ok && type_q[sel] == `TYPE_STD
				&& (op_a_q == 16'h0 || (freq_ok(op_a_q) && (op_mode_q == `SPEED_CONT
				|| (op_mode_q == `SPEED_INDEP && (cnt_set_q[sel] || run_w[sel])))));
			pulse_train_pkg::OP_COUNT: go_ok = port_ok && !run_w[sel] && count_w != 24'h0
				&& cnt_hi_q[15:8] == 8'h0 && op_mode_q[15:1] == 15'h0;
			pulse_train_pkg::OP_TRAP: go_ok = active_pulse_q && port_ok
				&& type_q[sel] == `TYPE_STD && freq_ok(op_a_q) && freq_ok(op_b_q)
				&& count_w != 24'h0 && cnt_hi_q[15:8] == 8'h0;
			pulse_train_pkg::OP_ACCEL: begin
				go_ok = port_ok && type_q[sel] == `TYPE_STD && freq_ok(op_b_q)
					&& op_mode_q[15:2] == 14'h0;
				unique case (op_mode_q[1:0])
					2'h0: go_ok = go_ok && active_pulse_q && cnt_set_q[sel]
						&& freq_ok(op_a_q) && freq_ok(op_c_q) && freq_ok(op_d_q);
					2'h1: go_ok = go_ok && freq_ok(op_a_q);
					2'h2: go_ok = go_ok && run_w[sel] && counted_q[sel] && op_a_q <= `FREQ_MAX;
					2'h3: go_ok = go_ok && run_w[sel] && op_a_q <= `FREQ_MAX;
				endcase
			end
			pulse_train_pkg::OP_DUTY: go_ok = port_ok && type_q[sel] == `TYPE_DUTY
				&& op_mode_q <= `PWM_CODE_MAX && duty_ok;
			pulse_train_pkg::OP_STOP: go_ok = port_ok && op_mode_q == `STOP_CODE;
			pulse_train_pkg::OP_TABLE: go_ok = port_ok && !active_pulse_q;
			pulse_train_pkg::OP_STATUS: go_ok = port_ok;
			default: go_ok = 1'b0;
		endcase
	end

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			run_w[p] = st_q[p] == pulse_train_pkg::ST_RUN || st_q[p] == pulse_train_pkg::ST_UP
				|| st_q[p] == pulse_train_pkg::ST_DN;
			fin_w[p] = counted_q[p] && run_w[p] && pulse_ev[p] && pv_q[p] + 24'h1 >= total_q[p];
			std_en_w[p] = run_w[p] && type_q[p] == `TYPE_STD;
			duty_en_w[p] = st_q[p] == pulse_train_pkg::ST_PWM && type_q[p] == `TYPE_DUTY;
			stat_w[p] = {duty_en_w[p], run_w[p] || duty_en_w[p], done_q[p], cnt_set_q[p],
				decel_q[p]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-port sequencing: command first, then completion, then ramp step
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (!rst_b) begin
				st_q[p] <= pulse_train_pkg::ST_IDLE;
				freq_q[p] <= 13'h0;
				tgt_q[p] <= 13'h0;
				rate_q[p] <= 13'h0;
				tgt2_q[p] <= 13'h0;
				rate2_q[p] <= 13'h0;
				total_q[p] <= 24'h0;
				decpt_q[p] <= 24'h0;
				pv_q[p] <= 24'h0;
				acc_q[p] <= 24'h0;
				per_q[p] <= 21'h0;
				high_q[p] <= 21'h0;
				{counted_q[p], trap_q[p], two_q[p], phase2_q[p], decel_q[p]} <= 5'h0;
				{cnt_set_q[p], done_q[p], dir_q[p]} <= 3'h0;
			end else if (go && sel == 1'(p)) begin
				unique case (op)
					pulse_train_pkg::OP_SPEED: begin
						decel_q[p] <= 1'b0;
						trap_q[p] <= 1'b0;
						two_q[p] <= 1'b0;
						freq_q[p] <= op_a_q[12:0];
						st_q[p] <= (op_a_q == 16'h0) ? pulse_train_pkg::ST_IDLE
							: pulse_train_pkg::ST_RUN;
						if (!run_w[p]) begin
							pv_q[p] <= 24'h0;
							done_q[p] <= 1'b0;
							counted_q[p] <= op_mode_q == `SPEED_INDEP;
						end
					end
					pulse_train_pkg::OP_COUNT: begin
						dir_q[p] <= op_mode_q[0];
						total_q[p] <= count_w;
						decpt_q[p] <= decel_w;
						cnt_set_q[p] <= 1'b1;
						done_q[p] <= 1'b0;
					end
					pulse_train_pkg::OP_TRAP: begin
						dir_q[p] <= op_mode_q[0];
						total_q[p] <= count_w;
						cnt_set_q[p] <= 1'b1;
						tgt_q[p] <= op_a_q[12:0];
						rate_q[p] <= op_b_q[12:0];
						freq_q[p] <= (op_b_q < op_a_q) ? op_b_q[12:0] : op_a_q[12:0];
						st_q[p] <= pulse_train_pkg::ST_UP;
						{counted_q[p], trap_q[p], two_q[p], phase2_q[p], decel_q[p]} <= 5'h18;
						pv_q[p] <= 24'h0;
						acc_q[p] <= 24'h0;
						done_q[p] <= 1'b0;
					end
					pulse_train_pkg::OP_ACCEL: begin
						tgt_q[p] <= op_a_q[12:0];
						rate_q[p] <= op_b_q[12:0];
						tgt2_q[p] <= op_c_q[12:0];
						rate2_q[p] <= op_d_q[12:0];
						phase2_q[p] <= 1'b0;
						trap_q[p] <= 1'b0;
						two_q[p] <= op_mode_q[1:0] == 2'h0;
						decel_q[p] <= op_mode_q[1];
						st_q[p] <= op_mode_q[1] ? pulse_train_pkg::ST_DN : pulse_train_pkg::ST_UP;
						if (op_mode_q[1:0] == 2'h0) begin
							counted_q[p] <= 1'b1;
							pv_q[p] <= 24'h0;
							done_q[p] <= 1'b0;
						end
						if (op_mode_q[1:0] == 2'h1) counted_q[p] <= 1'b0;
					end
					pulse_train_pkg::OP_DUTY: begin
						st_q[p] <= pulse_train_pkg::ST_PWM;
						per_q[p] <= per_sel;
						high_q[p] <= high_w;
						freq_q[p] <= 13'h0;
						counted_q[p] <= 1'b0;
						done_q[p] <= 1'b0;
					end
					pulse_train_pkg::OP_STOP: begin
						st_q[p] <= pulse_train_pkg::ST_IDLE;
						freq_q[p] <= 13'h0;
						decel_q[p] <= 1'b0;
					end
					default: begin
					end
				endcase
			end else begin
				if (run_w[p] && pulse_ev[p]) pv_q[p] <= pv_q[p] + 24'h1;
				if (st_q[p] == pulse_train_pkg::ST_UP && pulse_ev[p]) acc_q[p] <= acc_q[p] + 24'h1;
				if (fin_w[p]) begin
					st_q[p] <= pulse_train_pkg::ST_IDLE;
					freq_q[p] <= 13'h0;
					done_q[p] <= 1'b1;
					cnt_set_q[p] <= 1'b0;
					decel_q[p] <= 1'b0;
				end else if (tick) begin
					unique case (st_q[p])
						pulse_train_pkg::ST_UP: begin
							if (14'(freq_q[p]) + 14'(rate_q[p]) >= 14'(tgt_q[p])) begin
								freq_q[p] <= tgt_q[p];
								st_q[p] <= pulse_train_pkg::ST_RUN;
							end else begin
								freq_q[p] <= freq_q[p] + rate_q[p];
							end
						end
						pulse_train_pkg::ST_DN: begin
							if (14'(freq_q[p]) <= 14'(tgt_q[p]) + 14'(rate_q[p])) begin
								freq_q[p] <= tgt_q[p];
								decel_q[p] <= 1'b0;
								st_q[p] <= (tgt_q[p] == 13'h0) ? pulse_train_pkg::ST_IDLE
									: pulse_train_pkg::ST_RUN;
							end else begin
								freq_q[p] <= freq_q[p] - rate_q[p];
							end
						end
						pulse_train_pkg::ST_RUN: begin
							if (trap_q[p] && !phase2_q[p] && total_q[p] - pv_q[p] <= acc_q[p]) begin
								st_q[p] <= pulse_train_pkg::ST_DN;
								tgt_q[p] <= 13'h1;
								phase2_q[p] <= 1'b1;
								decel_q[p] <= 1'b1;
							end else if (two_q[p] && !phase2_q[p] && pv_q[p] >= decpt_q[p]) begin
								st_q[p] <= pulse_train_pkg::ST_DN;
								tgt_q[p] <= tgt2_q[p];
								rate_q[p] <= rate2_q[p];
								phase2_q[p] <= 1'b1;
								decel_q[p] <= 1'b1;
							end
						end
						pulse_train_pkg::ST_IDLE, pulse_train_pkg::ST_PWM: begin
						end
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command result, status read and register read-back
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			result_q <= 2'h0;
			rdstat_q <= 16'h0;
			rdata_q <= 16'h0;
		end else begin
			if (cmd_go) result_q <= go_ok ? `RES_OK : `RES_REFUSED;
			if (go && op == pulse_train_pkg::OP_STATUS) rdstat_q <= {8'h0, stat_w[sel][3:0], 4'h0};
			if (rd) begin
				unique case (addr)
					`OFF_PORT: rdata_q <= op_port_q;
					`OFF_MODE: rdata_q <= op_mode_q;
					`OFF_OPA: rdata_q <= op_a_q;
					`OFF_OPB: rdata_q <= op_b_q;
					`OFF_OPC: rdata_q <= op_c_q;
					`OFF_OPD: rdata_q <= op_d_q;
					`OFF_CNT_LO: rdata_q <= cnt_lo_q;
					`OFF_CNT_HI: rdata_q <= cnt_hi_q;
					`OFF_DEC_LO: rdata_q <= dec_lo_q;
					`OFF_DEC_HI: rdata_q <= dec_hi_q;
					`OFF_RESULT: rdata_q <= {14'h0, result_q};
					`OFF_STAT1: rdata_q <= {11'h0, stat_w[0]};
					`OFF_STAT2: rdata_q <= {11'h0, stat_w[1]};
					`OFF_RDSTAT: rdata_q <= rdstat_q;
					`OFF_RUN: rdata_q <= {14'h0, started_q, run_q};
					`OFF_PMODE: rdata_q <= pmode_q;
					`OFF_TYPE1: rdata_q <= type_q[0];
					`OFF_TYPE2: rdata_q <= type_q[1];
					default: rdata_q <= 16'h0;
				endcase
			end
		end
	end
	assign rdata = rdata_q;
	assign dir_out = dir_q;

	////////////////////////////////////////////////////////////////////////////////
	port_drive_if drv [2] ();
	generate
		for (genvar g = 0; g < 2; g++) begin : g_port
			assign drv[g].std_en = std_en_w[g];
			assign drv[g].freq = freq_q[g];
			assign drv[g].duty_en = duty_en_w[g];
			assign drv[g].per = per_q[g];
			assign drv[g].high = high_q[g];
			assign pulse_ev[g] = drv[g].pulse_ev;
			assign pulse_out[g] = drv[g].wave;
			pulse_gen u_gen (
				.clk   (clk),
				.rst_b (rst_b),
				.drv   (drv[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_cmd(logic [3:0] o);
		cmd_go && wdata[3:0] == o;
	endsequence

	a_counter_refuse: assert property (s_cmd(4'h3) ##0 !active_pulse_q |=> result_q == 2'h2)
		else $error("trapezoid accepted in counter mode");
	a_table_refuse: assert property (s_cmd(4'h7) ##0 active_pulse_q |=> result_q == 2'h2)
		else $error("comparison table accepted in pulse mode");
	a_mode_frozen: assert property (started_q |=> $stable(active_pulse_q))
		else $error("port mode changed after start-up");
	a_std_no_duty: assert property (type_q[0] == `TYPE_STD |-> !duty_en_w[0])
		else $error("standard port emitting duty pulses");
	a_duty_no_std: assert property (type_q[1] == `TYPE_DUTY |-> !std_en_w[1])
		else $error("duty port emitting standard pulses");
	a_duty_start: assert property (s_cmd(4'h5) ##0 go && sel |=> duty_en_w[1])
		else $error("duty output did not start");
	a_stop_halts: assert property (s_cmd(4'h6) ##0 go && !sel
		|=> st_q[0] == pulse_train_pkg::ST_IDLE ##1 !pulse_out[0])
		else $error("stop command did not halt port");
	a_count_done: assert property (fin_w[0] && !(go && !sel) |=> !run_w[0] && done_q[0])
		else $error("counted output overran its total");
	a_status_read: assert property (s_cmd(4'h8) ##0 go
		|=> rdstat_q == {8'h0, $past(stat_w[sel][3:0]), 4'h0})
		else $error("status read returned wrong flags");
	a_bad_refused: assert property (cmd_go && !go_ok |=> result_q == 2'h2)
		else $error("invalid command not refused");
endmodule

// File: motor_drive_model.sv
// Motor driver stand-in: counts pulses and measures period and high time per port
`timescale 1ns/1ps
module motor_drive_model (
	input wire logic       clk,
	input wire logic [1:0] pulse_in
);
	int         cyc = 0;
	int         n[2] = '{0, 0};
	int         rise_at[2] = '{0, 0};
	int         per[2] = '{0, 0};
	int         hi[2] = '{0, 0};
	logic [1:0] last = 2'h0;

	// Edges are seen on the rising clock, as the driver's opto input would latch them
	always @(posedge clk) begin
		cyc++;
		for (int i = 0; i < 2; i++) begin
			if (pulse_in[i] === 1'b1 && last[i] === 1'b0) begin
				n[i]++;
				per[i] = cyc - rise_at[i];
				rise_at[i] = cyc;
			end
			if (pulse_in[i] === 1'b0 && last[i] === 1'b1) begin
				hi[i] = cyc - rise_at[i];
			end
		end
		last = pulse_in;
	end
endmodule

// File: tb.sv
// Self-checking bench for the two-port pulse output unit
`timescale 1ns/1ps
`include "pulse_train_map.svh"
module tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic [1:0]  pulse_out;
	logic [1:0]  dir_out;
	int          fails = 0;
	int          n_tests = 0;
	int          snap;
	logic [15:0] bcd[3] = '{16'h0050, 16'h0025, 16'h0010};
	int          pp[3] = '{40, 60, 80};
	int          hh[3] = '{20, 15, 8};

	always #5 clk = ~clk;

	pulse_train_top #(.RAMP_TICKS(20), .PWM_PER0(40), .PWM_PER1(60), .PWM_PER2(80)) i_dut (
		.clk       (clk),
		.rst_b     (rst_b),
		.addr      (addr),
		.wdata     (wdata),
		.wr        (wr),
		.rd        (rd),
		.rdata     (rdata),
		.pulse_out (pulse_out),
		.dir_out   (dir_out)
	);

	motor_drive_model i_motor (
		.clk      (clk),
		.pulse_in (pulse_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({16'h0000, rdata & m}, {16'h0000, e});
	endtask

	// Loads operands, issues the opcode and checks the result code
	task automatic cmd(input logic [15:0] p, input logic [15:0] m, input logic [15:0] a,
		input logic [15:0] b, input pulse_train_pkg::cmd_op_type op, input logic [1:0] res);
		wr_reg(`OFF_PORT, p);
		wr_reg(`OFF_MODE, m);
		wr_reg(`OFF_OPA, a);
		wr_reg(`OFF_OPB, b);
		wr_reg(`OFF_CMD, {12'h000, op});
		rd_chk(`OFF_RESULT, 16'h0003, {14'h0000, res});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#900000;
		fails++;
		test_done;
	end

	initial begin
		do_reset;
		rd_chk(`OFF_PMODE, 16'hffff, `PMODE_RST);
		rd_chk(16'h0100, 16'hffff, 16'h0000);
		wr_reg(`OFF_RUN, 16'h0001);
		cmd(`PORT1, 16'h0000, 16'h0064, 16'h0032, pulse_train_pkg::OP_TRAP, `RES_REFUSED);
		cmd(`PORT1, 16'h0000, 16'h0064, 16'h0032, pulse_train_pkg::OP_ACCEL, `RES_REFUSED);
		cmd(`PORT1, 16'h0000, 16'h0000, 16'h0000, pulse_train_pkg::OP_TABLE, `RES_OK);
		wr_reg(`OFF_PMODE, `MODE_PULSE);
		rd_chk(`OFF_PMODE, 16'hffff, `MODE_COUNTER);
		wr_reg(`OFF_RUN, 16'h0000);
		wr_reg(`OFF_PMODE, `MODE_PULSE);
		wr_reg(`OFF_RUN, 16'h0001);
		cmd(`PORT1, 16'h0000, 16'h0064, 16'h0032, pulse_train_pkg::OP_TRAP, `RES_REFUSED);
		do_reset;
		rd_chk(`OFF_PMODE, 16'hffff, `PMODE_RST);
		wr_reg(`OFF_PMODE, `MODE_PULSE);
		wr_reg(`OFF_TYPE2, `TYPE_DUTY);
		rd_chk(`OFF_TYPE2, 16'hffff, `TYPE_DUTY);
		rd_chk(`OFF_TYPE1, 16'hffff, `TYPE_STD);
		wr_reg(`OFF_RUN, 16'h0001);
		cmd(`PORT1, 16'h0000, 16'h0000, 16'h0000, pulse_train_pkg::OP_TABLE, `RES_REFUSED);
		wr_reg(`OFF_CNT_LO, 16'h0005);
		wr_reg(`OFF_CNT_HI, 16'h0000);
		cmd(`PORT1, 16'h0001, 16'h0000, 16'h0000, pulse_train_pkg::OP_COUNT, `RES_OK);
		cmd(`PORT1, `SPEED_INDEP, `FREQ_MAX, 16'h0000, pulse_train_pkg::OP_SPEED, `RES_OK);
		chk({30'h0, dir_out}, 32'h1);
		repeat (15000) @(posedge clk);
		chk(i_motor.n[0], 5);
		rd_chk(`OFF_STAT1, 16'h000c, 16'h0004);
		cmd(`PORT1, 16'h0000, 16'h0000, 16'h0000, pulse_train_pkg::OP_STATUS, `RES_OK);
		rd_chk(`OFF_RDSTAT, 16'h00c0, 16'h0040);
		cmd(`PORT1, 16'h0000, 16'h0050, 16'h0000, pulse_train_pkg::OP_DUTY, `RES_REFUSED);
		for (int i = 0; i < 3; i++) begin
			cmd(`PORT2, 16'(i), bcd[i], 16'h0000, pulse_train_pkg::OP_DUTY, `RES_OK);
			repeat (300) @(posedge clk);
			chk(i_motor.per[1], pp[i]);
			chk(i_motor.hi[1], hh[i]);
		end
		cmd(`PORT2, 16'h0003, 16'h0050, 16'h0000, pulse_train_pkg::OP_DUTY, `RES_REFUSED);
		cmd(`PORT2, 16'h0000, 16'h0100, 16'h0000, pulse_train_pkg::OP_DUTY, `RES_REFUSED);
		cmd(`PORT2, `SPEED_CONT, 16'h0064, 16'h0000, pulse_train_pkg::OP_SPEED, `RES_REFUSED);
		cmd(`PORT2, 16'h0002, 16'h0000, 16'h0000, pulse_train_pkg::OP_STOP, `RES_REFUSED);
		repeat (300) @(posedge clk);
		chk(i_motor.per[1], 80);
		chk(i_motor.hi[1], 8);
		rd_chk(`OFF_STAT2, 16'h0010, 16'h0010);
		wr_reg(`OFF_CNT_LO, 16'h0400);
		cmd(`PORT1, 16'h0000, `FREQ_MAX, 16'h03e8, pulse_train_pkg::OP_TRAP, `RES_OK);
		chk({30'h0, dir_out}, 32'h0);
		snap = i_motor.n[0];
		repeat (20000) @(posedge clk);
		chk({31'h0, i_motor.n[0] > snap + 3}, 32'h1);
		rd_chk(`OFF_STAT1, 16'h0008, 16'h0008);
		cmd(`PORT1, 16'h0002, 16'h0000, 16'h03e8, pulse_train_pkg::OP_ACCEL, `RES_OK);
		repeat (200) @(posedge clk);
		rd_chk(`OFF_STAT1, 16'h000c, 16'h0000);
		wr_reg(`OFF_DEC_LO, 16'h0003);
		wr_reg(`OFF_OPC, 16'h07d0);
		wr_reg(`OFF_OPD, 16'h03e8);
		cmd(`PORT1, 16'h0000, 16'h0000, 16'h0000, pulse_train_pkg::OP_COUNT, `RES_OK);
		cmd(`PORT1, 16'h0000, `FREQ_MAX, 16'h03e8, pulse_train_pkg::OP_ACCEL, `RES_OK);
		repeat (25000) @(posedge clk);
		chk(i_motor.per[0], 5000);
		cmd(`PORT1, `STOP_CODE, 16'h0000, 16'h0000, pulse_train_pkg::OP_STOP, `RES_OK);
		cmd(`PORT2, `STOP_CODE, 16'h0000, 16'h0000, pulse_train_pkg::OP_STOP, `RES_OK);
		repeat (100) @(posedge clk);
		snap = i_motor.n[1];
		repeat (300) @(posedge clk);
		chk(i_motor.n[1], snap);
		chk({30'h0, pulse_out}, 32'h0);
		test_done;
	end
endmodule
